// ==== src/sdbs_bank_ctrl.sv ====
// Notes on behaviour
// - Self refresh is refresh with clock enable low
// - In self refresh only clock enable matters
// - Self refresh refreshes on internal timer
// - Both refresh modes advance one row counter
// - Inhibit and no-op continue current operation
// - Idle bank takes activate, refresh, mode, precharge
// - Precharge to idle bank does nothing
// - Refresh and mode load need all banks idle
// - Row active takes read, write, precharge
// - Read burst takes read, write, stop, precharge
// - Write burst takes read, write, stop, precharge
// - Burst stop ends most recent burst
// - Idle after precharge time, active after delay
// - Auto precharge state lasts precharge time
// - Bank behaviour needs clock enable high twice
`timescale 1ns/100ps
`default_nettype none
module sdbs_bank_ctrl
  import sdbs_pkg::*;
#(
  parameter int T_RP = PRECHARGE_TIME_CYC,
  parameter int T_RCD = ROW_TO_COLUMN_DELAY_CYC,
  parameter int T_RFC = REFRESH_CYCLE_TIME_CYC,
  parameter int T_MRD = MODE_LOAD_DELAY_CYC,
  parameter int T_XSR = SELF_REFRESH_EXIT_TIME_CYC,
  parameter int T_SRI = SELF_REFRESH_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire sdbs_pins_t pins,
  output sdbs_status_t status,
  output logic [NUM_BANKS*7-1:0] bank_states,
  output logic illegal_cmd
);

  // Command decode from the strobe pattern
  function automatic sdbs_cmd_t decode(input sdbs_pins_t p);
    sdbs_cmd_t c;
    c = SDBS_CMD_INHIBIT;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h7: c = SDBS_CMD_NOP;
        3'h3: c = SDBS_CMD_ACTIVE;
        3'h5: c = SDBS_CMD_READ;
        3'h4: c = SDBS_CMD_WRITE;
        3'h6: c = SDBS_CMD_STOP;
        3'h2: c = SDBS_CMD_PRECHARGE;
        3'h1: c = SDBS_CMD_REFRESH;
        3'h0: c = SDBS_CMD_MODE;
        default: c = SDBS_CMD_NOP;
      endcase
    end
    return c;
  endfunction

  sdbs_cmd_t cmd; // Decoded command this cycle
  logic cke_prev_q, cke_prev_d; // Clock enable a cycle ago
  logic exec; // Bank commands may act
  sdbs_dev_t dev_q, dev_d; // Device-wide state
  logic [CNT_W-1:0] dev_cnt_q, dev_cnt_d; // Device wait counter
  logic [CNT_W-1:0] sri_q, sri_d; // Internal refresh timer
  logic [ROWCNT_W-1:0] row_q, row_d; // Shared row refresh counter
  logic [BANK_W-1:0] last_q, last_d; // Bank of newest burst
  logic last_vld_q, last_vld_d; // A burst was started
  logic int_ref; // Internal refresh pulse
  logic all_idle; // Every bank idle
  sdbs_bank_t bst_q [NUM_BANKS]; // Bank states
  sdbs_bank_t bst_d [NUM_BANKS];
  logic [CNT_W-1:0] bcnt_q [NUM_BANKS]; // Bank wait counters
  logic [CNT_W-1:0] bcnt_d [NUM_BANKS];
  logic [NUM_BANKS-1:0] idle_vec; // Per-bank idle flags
  logic [NUM_BANKS-1:0] ill_vec; // Per-bank illegal flags

  assign cmd = decode(pins);
  assign exec = pins.cke && cke_prev_q && (dev_q == SDBS_DEV_NORMAL);
  assign all_idle = &idle_vec;

  // Device state: refresh, mode load, self refresh
  always_comb begin
    dev_d = dev_q;
    dev_cnt_d = dev_cnt_q;
    sri_d = sri_q;
    int_ref = 1'b0;
    row_d = row_q;
    cke_prev_d = pins.cke;
    case (dev_q)
      SDBS_DEV_NORMAL: begin
        if (!pins.cs_n && cmd == SDBS_CMD_REFRESH && all_idle && cke_prev_q) begin
          row_d = row_q + 1'b1;
          dev_cnt_d = CNT_W'(T_RFC);
          dev_d = pins.cke ? SDBS_DEV_REFRESH : SDBS_DEV_SELF_REF;
          sri_d = CNT_W'(T_SRI);
        end else if (exec && cmd == SDBS_CMD_MODE && all_idle) begin
          dev_cnt_d = CNT_W'(T_MRD);
          dev_d = SDBS_DEV_MODE_LOAD;
        end
      end
      SDBS_DEV_REFRESH, SDBS_DEV_MODE_LOAD: begin
        // Waits out refresh cycle or mode load delay
        if (dev_cnt_q <= CNT_W'(1)) begin
          dev_d = SDBS_DEV_NORMAL;
        end else begin
          dev_cnt_d = dev_cnt_q - 1'b1;
        end
      end
      SDBS_DEV_SELF_REF: begin
        // Only clock enable is looked at here
        if (sri_q <= CNT_W'(1)) begin
          sri_d = CNT_W'(T_SRI);
          int_ref = 1'b1;
          row_d = row_q + 1'b1;
        end else begin
          sri_d = sri_q - 1'b1;
        end
        if (pins.cke) begin
          dev_d = SDBS_DEV_SR_EXIT;
          dev_cnt_d = CNT_W'((T_XSR > SELF_REFRESH_EXIT_MIN_CYC) ? T_XSR : SELF_REFRESH_EXIT_MIN_CYC);
        end
      end
      SDBS_DEV_SR_EXIT: begin
        // Exit time ignores commands
        if (dev_cnt_q <= CNT_W'(1)) begin
          dev_d = SDBS_DEV_NORMAL;
        end else begin
          dev_cnt_d = dev_cnt_q - 1'b1;
        end
      end
      default: dev_d = SDBS_DEV_NORMAL;
    endcase
  end

  // Device state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_q <= SDBS_DEV_NORMAL;
      dev_cnt_q <= '0;
      sri_q <= '0;
      row_q <= '0;
      cke_prev_q <= 1'b0;
    end else begin
      dev_q <= dev_d;
      dev_cnt_q <= dev_cnt_d;
      sri_q <= sri_d;
      row_q <= row_d;
      cke_prev_q <= cke_prev_d;
    end
  end

  // Newest burst tracking
  always_comb begin
    last_d = last_q;
    last_vld_d = last_vld_q;
    if (exec && (cmd == SDBS_CMD_READ || cmd == SDBS_CMD_WRITE)) begin
      last_d = pins.bank;
      last_vld_d = 1'b1;
    end else if (exec && cmd == SDBS_CMD_STOP) begin
      last_vld_d = 1'b0;
    end
  end

  // Burst tracking registers
  always_ff @(posedge clk) begin
    if (rst) begin
      last_q <= '0;
      last_vld_q <= 1'b0;
    end else begin
      last_q <= last_d;
      last_vld_q <= last_vld_d;
    end
  end

  // Per-bank state machines
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic sel; // Command names this bank
    logic pre_hit; // Precharge reaches this bank
    assign sel = (pins.bank == BANK_W'(b));
    assign pre_hit = exec && cmd == SDBS_CMD_PRECHARGE && (pins.a10 || sel);
    assign idle_vec[b] = (bst_q[b] == SDBS_IDLE);
    assign bank_states[b*7 +: 7] = bst_q[b];

    // Next bank state
    always_comb begin
      bst_d[b] = bst_q[b];
      bcnt_d[b] = (bcnt_q[b] != '0) ? bcnt_q[b] - 1'b1 : bcnt_q[b];
      ill_vec[b] = 1'b0;
      case (bst_q[b])
        SDBS_IDLE: begin
          // Precharge here leaves the bank idle
          if (exec && sel && cmd == SDBS_CMD_ACTIVE) begin
            bst_d[b] = SDBS_ACTIVATING;
            bcnt_d[b] = CNT_W'(T_RCD);
          end
        end
        SDBS_ACTIVATING, SDBS_PRECHARGING, SDBS_AUTO_PRE: begin
          // Same-bank commands not allowed
          if (exec && sel && cmd != SDBS_CMD_INHIBIT && cmd != SDBS_CMD_NOP) begin
            ill_vec[b] = 1'b1;
          end
          if (bcnt_q[b] <= CNT_W'(1)) begin
            bst_d[b] = (bst_q[b] == SDBS_ACTIVATING) ? SDBS_ROW_ACTIVE : SDBS_IDLE;
          end
        end
        SDBS_ROW_ACTIVE, SDBS_READ, SDBS_WRITE: begin
          if (pre_hit) begin
            bst_d[b] = SDBS_PRECHARGING;
            bcnt_d[b] = CNT_W'(T_RP);
          end else if (exec && sel && (cmd == SDBS_CMD_READ || cmd == SDBS_CMD_WRITE)) begin
            if (pins.a10) begin
              bst_d[b] = SDBS_AUTO_PRE;
              bcnt_d[b] = CNT_W'(T_RP);
            end else begin
              bst_d[b] = (cmd == SDBS_CMD_READ) ? SDBS_READ : SDBS_WRITE;
            end
          end else if (exec && cmd == SDBS_CMD_STOP && last_vld_q && last_q == BANK_W'(b)) begin
            bst_d[b] = SDBS_ROW_ACTIVE;
          end else if (exec && (cmd == SDBS_CMD_READ || cmd == SDBS_CMD_WRITE) && bst_q[b] != SDBS_ROW_ACTIVE) begin
            bst_d[b] = SDBS_ROW_ACTIVE; // Burst cut by another bank
          end else if (exec && sel && cmd == SDBS_CMD_ACTIVE) begin
            ill_vec[b] = 1'b1;
          end
        end
        default: bst_d[b] = SDBS_IDLE;
      endcase
    end

    // Bank registers
    always_ff @(posedge clk) begin
      if (rst) begin
        bst_q[b] <= SDBS_IDLE;
        bcnt_q[b] <= '0;
      end else begin
        bst_q[b] <= bst_d[b];
        bcnt_q[b] <= bcnt_d[b];
      end
    end
  end

  // Status outputs; illegal flag for device-wide misuse too
  always_comb begin
    status.self_refresh = (dev_q == SDBS_DEV_SELF_REF);
    status.internal_refresh = int_ref;
    status.all_idle = all_idle;
    status.busy = (dev_q != SDBS_DEV_NORMAL);
    status.row_counter = row_q;
    illegal_cmd = (|ill_vec)
      || (exec && (cmd == SDBS_CMD_REFRESH || cmd == SDBS_CMD_MODE) && !all_idle)
      || (pins.cke && (dev_q == SDBS_DEV_REFRESH || dev_q == SDBS_DEV_MODE_LOAD)
          && !pins.cs_n && cmd != SDBS_CMD_NOP);
  end

  // Refresh with enable low enters self refresh
  a_sr_entry: assert property (@(posedge clk) disable iff (rst)
    (dev_q == SDBS_DEV_NORMAL && cke_prev_q && !pins.cke && cmd == SDBS_CMD_REFRESH && all_idle)
    |=> dev_q == SDBS_DEV_SELF_REF) else $error("self refresh not entered");
  // Refresh advances the row counter
  a_row_count: assert property (@(posedge clk) disable iff (rst)
    (dev_q == SDBS_DEV_NORMAL && dev_d == SDBS_DEV_REFRESH) |=> row_q == $past(row_q) + 1'b1)
    else $error("row counter not advanced");
  // Exit wait holds at least two cycles
  a_sr_exit: assert property (@(posedge clk) disable iff (rst)
    (dev_q == SDBS_DEV_SELF_REF && pins.cke) |=> dev_q == SDBS_DEV_SR_EXIT ##1 dev_q == SDBS_DEV_SR_EXIT)
    else $error("self refresh exit too short");
  // Bank states frozen in self refresh
  a_sr_frozen: assert property (@(posedge clk) disable iff (rst)
    (dev_q == SDBS_DEV_SELF_REF) |=> $stable(bank_states)) else $error("bank moved in self refresh");
  // Activate reaches row active after the delay
  a_activate: assert property (@(posedge clk) disable iff (rst)
    (exec && cmd == SDBS_CMD_ACTIVE && bst_q[0] == SDBS_IDLE && pins.bank == '0)
    |=> bst_q[0] == SDBS_ACTIVATING ##[1:64] bst_q[0] == SDBS_ROW_ACTIVE) else $error("activate stuck");
  // Idle bank unchanged by precharge
  a_pre_idle: assert property (@(posedge clk) disable iff (rst)
    (exec && cmd == SDBS_CMD_PRECHARGE && bst_q[1] == SDBS_IDLE) |=> bst_q[1] == SDBS_IDLE)
    else $error("idle bank disturbed");
  // Precharge from read cuts burst
  a_pre_read: assert property (@(posedge clk) disable iff (rst)
    (exec && cmd == SDBS_CMD_PRECHARGE && pins.a10 && bst_q[2] == SDBS_READ) |=> bst_q[2] == SDBS_PRECHARGING)
    else $error("read not cut by precharge");
  // No bank action without clock enable twice
  a_cke_gate: assert property (@(posedge clk) disable iff (rst)
    (!cke_prev_q && bst_q[3] == SDBS_IDLE) |=> bst_q[3] == SDBS_IDLE) else $error("bank acted with enable low");
  // Inhibit or no-op lets a read burst run on
  a_burst_holds: assert property (@(posedge clk) disable iff (rst)
    (bst_q[0] == SDBS_READ && (cmd == SDBS_CMD_INHIBIT || cmd == SDBS_CMD_NOP)) |=> bst_q[0] == SDBS_READ)
    else $error("burst lost on no-op");
  // Same-bank command while activating is flagged
  a_flag_early: assert property (@(posedge clk) disable iff (rst)
    (exec && cmd == SDBS_CMD_READ && pins.bank == '0 && bst_q[0] == SDBS_ACTIVATING) |-> illegal_cmd)
    else $error("early command not flagged");
  // Access with auto precharge enters the auto precharge state
  a_auto_pre: assert property (@(posedge clk) disable iff (rst)
    (exec && (cmd == SDBS_CMD_READ || cmd == SDBS_CMD_WRITE) && pins.a10 && pins.bank == BANK_W'(2)
     && bst_q[2] == SDBS_ROW_ACTIVE) |=> bst_q[2] == SDBS_AUTO_PRE) else $error("auto precharge not entered");
  // Mode load makes the device busy
  a_mode_busy: assert property (@(posedge clk) disable iff (rst)
    (exec && cmd == SDBS_CMD_MODE && all_idle) |=> status.busy) else $error("mode load not busy");
  // Internal refresh advances the row counter
  a_int_refresh: assert property (@(posedge clk) disable iff (rst)
    (dev_q == SDBS_DEV_SELF_REF && int_ref) |=> row_q == $past(row_q) + 1'b1) else $error("internal refresh lost");
endmodule
`default_nettype wire

// ==== src/sdbs_pkg.sv ====
package sdbs_pkg;
  // Bank count, bank address and counter widths
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int CNT_W = 16;
  localparam int ROWCNT_W = 12;
  // Clock period in ns
  localparam int CLK_PERIOD_NS = 25;
  // Default timing figures in ns, mode load and exit minimum in cycles (plain defaults)
  localparam int PRECHARGE_TIME_NS = 20;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 70;
  localparam int MIN_ROW_ACTIVE_TIME_NS = 44;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
  localparam int MODE_LOAD_DELAY_CYC = 2;
  localparam int SELF_REFRESH_EXIT_MIN_CYC = 2;
  // Internal refresh oscillator period in ns
  localparam int SELF_REFRESH_INTERVAL_NS = 15625;
  // Least times round up to whole cycles
  localparam int PRECHARGE_TIME_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TO_COLUMN_DELAY_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ROW_ACTIVE_TIME_CYC = (MIN_ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_TIME_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_INTERVAL_CYC = SELF_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;

  // Bank states, one-hot
  typedef enum logic [6:0] {
    SDBS_IDLE = 7'h01,
    SDBS_ACTIVATING = 7'h02,
    SDBS_ROW_ACTIVE = 7'h04,
    SDBS_READ = 7'h08,
    SDBS_WRITE = 7'h10,
    SDBS_PRECHARGING = 7'h20,
    SDBS_AUTO_PRE = 7'h40
  } sdbs_bank_t;

  // Device-wide states, one-hot
  typedef enum logic [4:0] {
    SDBS_DEV_NORMAL = 5'h01,
    SDBS_DEV_REFRESH = 5'h02,
    SDBS_DEV_MODE_LOAD = 5'h04,
    SDBS_DEV_SELF_REF = 5'h08,
    SDBS_DEV_SR_EXIT = 5'h10
  } sdbs_dev_t;

  // Decoded command
  typedef enum logic [3:0] {
    SDBS_CMD_INHIBIT = 4'h0,
    SDBS_CMD_NOP = 4'h1,
    SDBS_CMD_ACTIVE = 4'h2,
    SDBS_CMD_READ = 4'h3,
    SDBS_CMD_WRITE = 4'h4,
    SDBS_CMD_STOP = 4'h5,
    SDBS_CMD_PRECHARGE = 4'h6,
    SDBS_CMD_REFRESH = 4'h7,
    SDBS_CMD_MODE = 4'h8
  } sdbs_cmd_t;

  // Command pins as sampled on the rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [BANK_W-1:0] bank;
    logic a10;
  } sdbs_pins_t;

  // Status seen by the outside
  typedef struct packed {
    logic self_refresh;
    logic internal_refresh;
    logic all_idle;
    logic busy;
    logic [ROWCNT_W-1:0] row_counter;
  } sdbs_status_t;
endpackage

// ==== verification/sdbs_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdbs_ctrl_model
  import sdbs_pkg::*;
#(
  parameter int T_XSR = 3
) (
  input wire logic clk,
  output var sdbs_pins_t pins
);
  // Bus starts as a no-op with clock enable high
  initial begin
    pins = {4'h7, 1'b1, 2'h0, 1'b0};
  end
  // One command per falling edge, taken at the next rising edge
  task automatic cmd(input logic [3:0] code, input logic [1:0] bnk, input logic ap, input logic en);
    @(negedge clk);
    pins = {code, en, bnk, ap};
  endtask
  // Waits are filled with no-ops only
  task automatic nops(input int n);
    repeat (n) cmd(4'h7, 2'h0, 1'b0, 1'b1);
  endtask
  // Refresh code with enable low enters self refresh
  task automatic sr_enter();
    cmd(4'h1, 2'h0, 1'b0, 1'b0);
  endtask
  // Other lines wander while enable stays low, never shorter than the row time
  task automatic sr_hold(input int n);
    int i;
    for (i = 0; i < (n > MIN_ROW_ACTIVE_TIME_CYC ? n : MIN_ROW_ACTIVE_TIME_CYC); i++) begin
      cmd(i[0] ? 4'h3 : 4'hc, i[1:0], i[0], 1'b0);
    end
  endtask
  // Clock never stops; no-ops from the enable edge until the exit wait has ended
  task automatic sr_exit();
    nops((T_XSR > 2 ? T_XSR : 2) + 1);
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sdbs_pkg::*;
  // Simulation waits: refresh interval shortened; precharge, row delay and refresh cycle lengthened
  localparam int RP = 3, RCD = 3, RFC = 4, MRD = 2, XSR = 3, SRI = 8;
  // Strobe codes cs_n ras_n cas_n we_n
  localparam logic [3:0] C_ACT = 4'h3, C_RD = 4'h5, C_WR = 4'h4, C_STOP = 4'h6;
  localparam logic [3:0] C_PRE = 4'h2, C_REF = 4'h1, C_MRS = 4'h0, C_INH = 4'h8;
  logic clk, rst; // Clock and reset
  sdbs_pins_t pins; // Command lines from the model
  sdbs_status_t status; // Device status
  logic [NUM_BANKS*7-1:0] bank_states; // Per-bank states
  logic illegal_cmd; // Refused command flag
  int failures, checks_done, cycles, pulses, refs; // Bookkeeping
  sdbs_bank_ctrl #(.T_RP(RP), .T_RCD(RCD), .T_RFC(RFC), .T_MRD(MRD), .T_XSR(XSR), .T_SRI(SRI)) uut (
    .clk(clk), .rst(rst), .pins(pins), .status(status), .bank_states(bank_states), .illegal_cmd(illegal_cmd));
  sdbs_ctrl_model #(.T_XSR(XSR)) ctl (.clk(clk), .pins(pins));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cycle ceiling and internal refresh tally
  always @(posedge clk) begin
    cycles++;
    if (status.internal_refresh === 1'b1) begin
      pulses++;
    end
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // State of one bank
  function automatic logic [6:0] bk(input int b);
    return bank_states[b*7+:7];
  endfunction
  // Verdict and stop
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Open, burst, stop and close one bank
  task automatic t_basic();
    ctl.cmd(C_ACT, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("bank0 activating", bk(0), SDBS_ACTIVATING);
    ctl.cmd(C_RD, 2'h0, 1'b0, 1'b1);
    #1;
    chk("read while activating", illegal_cmd, 1'b1);
    ctl.nops(RCD);
    chk("bank0 row active", bk(0), SDBS_ROW_ACTIVE);
    ctl.cmd(C_RD, 2'h0, 1'b0, 1'b1);
    ctl.cmd(C_INH, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("read kept over inhibit", bk(0), SDBS_READ);
    ctl.cmd(C_WR, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("write after read", bk(0), SDBS_WRITE);
    ctl.cmd(C_STOP, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("stop to row active", bk(0), SDBS_ROW_ACTIVE);
    ctl.cmd(C_WR, 2'h0, 1'b0, 1'b1);
    ctl.cmd(C_PRE, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("precharge cuts write", bk(0), SDBS_PRECHARGING);
    ctl.nops(RP + 1);
    chk("bank0 idle", bk(0), SDBS_IDLE);
    chk("all idle", status.all_idle, 1'b1);
    $display("test basic done");
  endtask
  // Device-wide commands from all idle
  task automatic t_device();
    ctl.cmd(C_PRE, 2'h1, 1'b0, 1'b1);
    ctl.nops(1);
    chk("precharge idle bank", bk(1), SDBS_IDLE);
    ctl.cmd(C_MRS, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("mode load busy", status.busy, 1'b1);
    ctl.nops(MRD + 1);
    chk("mode load over", status.busy, 1'b0);
    ctl.cmd(C_REF, 2'h0, 1'b0, 1'b1);
    refs++;
    ctl.nops(1);
    chk("refresh busy", status.busy, 1'b1);
    chk("row counter", status.row_counter, ROWCNT_W'(refs + pulses));
    ctl.nops(RFC + 1);
    chk("refresh over", status.busy, 1'b0);
    $display("test device done");
  endtask
  // Read and write with auto precharge
  task automatic t_autopre();
    int k;
    for (k = 0; k < 2; k++) begin
      ctl.cmd(C_ACT, 2'h2, 1'b0, 1'b1);
      ctl.nops(RCD + 1);
      ctl.cmd(k == 0 ? C_RD : C_WR, 2'h2, 1'b1, 1'b1);
      ctl.nops(1);
      chk("auto precharge", bk(2), SDBS_AUTO_PRE);
      ctl.nops(RP + 1);
      chk("idle after auto precharge", bk(2), SDBS_IDLE);
    end
    $display("test autopre done");
  endtask
  // Stop hits the latest burst; precharge all
  task automatic t_two_banks();
    ctl.cmd(C_ACT, 2'h2, 1'b0, 1'b1);
    ctl.cmd(C_ACT, 2'h1, 1'b0, 1'b1);
    ctl.nops(RCD + 1);
    ctl.cmd(C_RD, 2'h2, 1'b0, 1'b1);
    ctl.cmd(C_WR, 2'h1, 1'b0, 1'b1);
    ctl.cmd(C_STOP, 2'h0, 1'b0, 1'b1);
    ctl.nops(1);
    chk("bank1 stopped", bk(1), SDBS_ROW_ACTIVE);
    chk("bank2 cut", bk(2), SDBS_ROW_ACTIVE);
    ctl.cmd(C_RD, 2'h2, 1'b0, 1'b1);
    ctl.cmd(C_PRE, 2'h0, 1'b1, 1'b1);
    ctl.nops(1);
    chk("all pre bank2", bk(2), SDBS_PRECHARGING);
    chk("all pre bank1", bk(1), SDBS_PRECHARGING);
    ctl.nops(RP + 1);
    chk("all idle after", status.all_idle, 1'b1);
    $display("test two banks done");
  endtask
  // Commands need clock enable high now and one cycle before
  task automatic t_cke_gate();
    ctl.cmd(C_ACT, 2'h3, 1'b0, 1'b0);
    ctl.cmd(C_ACT, 2'h3, 1'b0, 1'b1);
    ctl.nops(1);
    chk("act with enable low", bk(3), SDBS_IDLE);
    ctl.cmd(C_ACT, 2'h3, 1'b0, 1'b1);
    ctl.nops(RCD + 1);
    chk("act with enable high", bk(3), SDBS_ROW_ACTIVE);
    ctl.cmd(C_PRE, 2'h3, 1'b0, 1'b1);
    ctl.nops(RP + 1);
    chk("bank3 closed", bk(3), SDBS_IDLE);
    $display("test enable gate done");
  endtask
  // Self refresh entry, stay and exit
  task automatic t_self_ref();
    ctl.sr_enter();
    refs++;
    ctl.nops(0);
    ctl.sr_hold(3 * SRI);
    chk("in self refresh", status.self_refresh, 1'b1);
    chk("banks untouched", bank_states, {NUM_BANKS{7'h01}});
    chk("internal refresh count", pulses, (3 * SRI - 1) / SRI);
    chk("row counter in sr", status.row_counter, ROWCNT_W'(refs + pulses));
    ctl.sr_exit();
    ctl.nops(1);
    chk("out of self refresh", status.self_refresh, 1'b0);
    chk("exit wait over", status.busy, 1'b0);
    ctl.cmd(C_REF, 2'h0, 1'b0, 1'b1);
    refs++;
    ctl.nops(1);
    chk("row counter after", status.row_counter, ROWCNT_W'(refs + pulses));
    ctl.nops(RFC + 1);
    $display("test self refresh done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    pulses = 0;
    refs = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    ctl.nops(2);
    t_basic();
    t_device();
    t_autopre();
    t_two_banks();
    t_cke_gate();
    t_self_ref();
    end_of_test();
  end
endmodule
`default_nettype wire
